// File: design/udcp_core.sv
// usb device command port: opcode byte plus data bytes, two-entry
// read buffer, divided clock output from the 48 mhz clock
// assumes the usb engine feeds events on mclk; clk48 is a pin input
`timescale 1ns/100ps
// Overview of operation
// - four byte locations: configuration, command, write data, read data
// - chip id read as two bytes, low first
// - byte0 revision, byte1 name in low nibble
// - error opcode returns four-bit last error code
// - bit four flags error, cleared on new transfer
// - low error codes none through babble
// - high error codes eop through wrong toggle
// - frame opcode returns frame number in two bytes
// - interrupt opcode returns two source bytes
// - endpoint interrupt bits clear on endpoint select
// - status change bits clear on status read
// - refusal bit lets nak events raise interrupts
// - keep-clocks bit holds clocks through suspend
// - divided clock is 48 mhz over factor plus one, held high at factor 0
// - divider factor change never glitches output
// - bus reset leaves divider factor alone
// - endpoint enable, address, port status opcodes
// - select opcodes 00h-06h, optional one-byte read
// - select-clear 40h-46h, read byte mandatory
// - write versus read picks the shared opcode
// - clear/validate act on selected endpoint; one shared data buffer
// - config bit five selects pull-up resistor
module udcp_core
  import udcp_pkg::*;
#(
  parameter logic [7:0] REVISION = 8'h01, // arbitrary value
  parameter logic [3:0] PART_NAME = 4'h5  // arbitrary value
) (
  input  wire logic        mclk,                // bus clock
  input  wire logic        rst_n,               // async reset
  input  wire logic        clk_en,              // freezes state when low
  input  wire logic        clk48,               // 48 mhz pin
  input  wire logic [15:0] bus_addr,            // byte address
  input  wire logic        bus_wr,              // write strobe
  input  wire logic        bus_rd,              // read request
  input  wire logic [7:0]  bus_wdata,           // write data
  output logic      [7:0]  bus_rdata,           // read data
  output logic             bus_rvalid,          // read data valid
  input  wire logic        bus_rready,          // cpu takes read data
  input  wire logic        usb_bus_reset,       // usb bus reset event
  input  wire logic        sof_pulse,           // frame start
  input  wire logic [10:0] sof_frame,           // frame number
  input  wire logic        err_pulse,           // engine error event
  input  wire logic [3:0]  err_code,            // error encoding
  input  wire logic        xfer_start,          // new transfer
  input  wire logic [NUM_EP-1:0] ep_ack,        // ep transaction done
  input  wire logic [NUM_EP-1:0] ep_nak,        // ep nak sent
  input  wire logic        dev_stat_chg,        // device status change
  output logic             usb_int,             // interrupt to cpu
  output logic             divided_clock_out,   // divided clock
  output logic             pullup_select,       // 1 external pull-up
  output logic             keep_clocks_running, // hold clocks in suspend
  output logic             report_refusals,     // nak reporting
  output logic [6:0]       dev_address,         // device address
  output logic             dev_enable,          // function enable
  output logic [NUM_EP-1:0] ep_enable,          // endpoint enables
  output logic             port_connect         // embedded port on
);
  logic [7:0]  opcode_reg;
  udcp_phase_e phase_reg;
  logic [7:0]  setup_reg;
  logic [7:0]  mode_reg;
  logic [7:0]  div_reg;
  logic [4:0]  error_reg;
  logic [10:0] frame_reg;
  logic [NUM_EP_INT+1:0] int_reg;
  logic [15:0] ep_en_reg;
  logic [7:0]  addr_reg;
  logic        port_conn_reg;
  logic        port_chg_reg;
  logic [2:0]  sel_ep_reg;
  logic [1:0]  ep_stat_reg [NUM_EP];
  logic [7:0]  buf_mem [BUF_DEPTH];
  logic [5:0]  buf_ptr_reg;

  // write strobes decoded per location
  logic wr_op, wr_data, wr_setup, rd_req;
  assign wr_op    = clk_en && bus_wr && bus_addr == ADDR_OPCODE;
  assign wr_data  = clk_en && bus_wr && bus_addr == ADDR_WDATA;
  assign wr_setup = clk_en && bus_wr && bus_addr == ADDR_SETUP;

  function automatic logic is_sel(input logic [7:0] op);
    return op <= OP_SEL_LAST;
  endfunction
  function automatic logic is_selc(input logic [7:0] op);
    return op >= OP_SELC_BASE && op <= OP_SELC_LAST;
  endfunction

  // two-entry read buffer; a stalled cpu loses no byte
  logic [7:0] fifo_data [2];
  logic [1:0] fifo_cnt;
  logic       fifo_wr_ptr, fifo_rd_ptr;
  logic       fifo_ready, src_valid, pop;
  logic [7:0] src_byte;
  assign fifo_ready = fifo_cnt != 2'd2;
  assign pop = clk_en && bus_rvalid && bus_rready;
  // read requests only accepted while the buffer has room
  assign rd_req = clk_en && bus_rd && bus_addr == ADDR_RDATA
                  && fifo_ready;

  logic first_byte;
  assign first_byte = phase_reg == UDCP_PH_FIRST;
  assign src_valid  = rd_req && phase_reg != UDCP_PH_IDLE;

  always_comb begin
    src_byte = 8'h00;
    case (opcode_reg)
      OP_CHIP_ID: src_byte = first_byte ? REVISION
                                        : {4'h0, PART_NAME};
      OP_ERROR:   src_byte = {3'h0, error_reg};
      OP_FRAME:   src_byte = first_byte ? frame_reg[7:0]
                                        : {5'h00, frame_reg[10:8]};
      OP_INT_REG: src_byte = first_byte ? int_reg[7:0]
                                        : {4'h0, int_reg[11:8]};
      OP_PORT_STAT: src_byte = {6'h00, port_chg_reg, port_conn_reg};
      OP_BUFFER:  src_byte = buf_mem[buf_ptr_reg];
      OP_CLR_BUF: src_byte = 8'h00;
      default: begin
        if (is_sel(opcode_reg) || is_selc(opcode_reg)) begin
          src_byte = {6'h00, ep_stat_reg[sel_ep_reg]};
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fifo_cnt    <= 2'd0;
      fifo_wr_ptr <= 1'b0;
      fifo_rd_ptr <= 1'b0;
      fifo_data[0] <= 8'h00;
      fifo_data[1] <= 8'h00;
    end else if (clk_en) begin
      if (src_valid) begin
        fifo_data[fifo_wr_ptr] <= src_byte;
        fifo_wr_ptr <= ~fifo_wr_ptr;
      end
      if (pop) begin
        fifo_rd_ptr <= ~fifo_rd_ptr;
      end
      fifo_cnt <= fifo_cnt + {1'b0, src_valid} - {1'b0, pop};
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata  <= 8'h00;
      bus_rvalid <= 1'b0;
    end else if (clk_en) begin
      bus_rvalid <= (fifo_cnt - {1'b0, pop}) != 2'd0 || src_valid;
      if (fifo_cnt - {1'b0, pop} != 2'd0) begin
        bus_rdata <= fifo_data[pop ? ~fifo_rd_ptr : fifo_rd_ptr];
      end else if (src_valid) begin
        bus_rdata <= src_byte;
      end
    end
  end

  // command sequencer: opcode then its data phase
  logic data_evt;
  assign data_evt = wr_data || rd_req;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      opcode_reg <= 8'h00;
      phase_reg  <= UDCP_PH_IDLE;
    end else if (wr_op) begin
      opcode_reg <= bus_wdata;
      phase_reg  <= bus_wdata == OP_VALIDATE ? UDCP_PH_IDLE
                                             : UDCP_PH_FIRST;
    end else if (data_evt && phase_reg != UDCP_PH_IDLE) begin
      case (phase_reg)
        UDCP_PH_FIRST:  phase_reg <= opcode_reg == OP_BUFFER
                                     ? UDCP_PH_FIRST : UDCP_PH_SECOND;
        UDCP_PH_SECOND: phase_reg <= UDCP_PH_DONE;
        UDCP_PH_DONE:   phase_reg <= UDCP_PH_DONE;
        default:        phase_reg <= UDCP_PH_IDLE;
      endcase
    end
  end

  // configuration byte at its own location
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      setup_reg <= 8'h00;
    end else if (wr_setup) begin
      setup_reg <= bus_wdata;
    end
  end

  // mode and divider; usb bus reset deliberately not applied here
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= 8'h00;
      div_reg  <= DIV_RESET;
    end else if (wr_data && opcode_reg == OP_SET_MODE) begin
      if (first_byte) begin
        mode_reg <= bus_wdata;
      end else if (phase_reg == UDCP_PH_SECOND) begin
        div_reg <= bus_wdata;
      end
    end
  end

  // configuration writes, direction picks the command
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ep_en_reg     <= 16'h0000;
      addr_reg      <= 8'h00;
      port_conn_reg <= 1'b0;
    end else if (wr_data) begin
      if (opcode_reg == OP_EP_ENABLE && first_byte) begin
        ep_en_reg[7:0] <= bus_wdata;
      end else if (opcode_reg == OP_EP_ENABLE
                   && phase_reg == UDCP_PH_SECOND) begin
        ep_en_reg[15:8] <= bus_wdata;
      end else if (opcode_reg == OP_ADDRESS && first_byte) begin
        addr_reg <= bus_wdata;
      end else if (opcode_reg == OP_PORT_STAT && first_byte) begin
        port_conn_reg <= bus_wdata[0];
      end
    end
  end

  logic port_rd;
  assign port_rd = rd_req && opcode_reg == OP_PORT_STAT;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      port_chg_reg <= 1'b0;
    end else if (clk_en) begin
      // a new event beats the clearing read
      if (usb_bus_reset) begin
        port_chg_reg <= 1'b1;
      end else if (port_rd) begin
        port_chg_reg <= 1'b0;
      end
    end
  end

  // endpoint selection and per-endpoint status
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sel_ep_reg <= 3'd0;
    end else if (wr_op && (is_sel(bus_wdata) || is_selc(bus_wdata))) begin
      sel_ep_reg <= bus_wdata[2:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      buf_ptr_reg <= 6'd0;
    end else if (wr_op && is_sel(bus_wdata)) begin
      buf_ptr_reg <= 6'd0;
    end else if (data_evt && opcode_reg == OP_BUFFER) begin
      buf_ptr_reg <= buf_ptr_reg + 6'd1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < BUF_DEPTH; i++) begin
        buf_mem[i] <= 8'h00;
      end
    end else if (wr_data && opcode_reg == OP_BUFFER) begin
      buf_mem[buf_ptr_reg] <= bus_wdata;
    end
  end

  for (genvar e = 0; e < NUM_EP; e++) begin : g_ep
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        ep_stat_reg[e] <= 2'b00;
      end else if (clk_en && sel_ep_reg == 3'(e)) begin
        if (ep_ack[e]) begin
          ep_stat_reg[e][FULL_BIT] <= 1'b1;
        end else if (wr_op && bus_wdata == OP_VALIDATE) begin
          ep_stat_reg[e][FULL_BIT] <= 1'b1;
        end else if (wr_op && bus_wdata == OP_CLR_BUF) begin
          ep_stat_reg[e][FULL_BIT] <= 1'b0;
        end
        if (wr_data && is_selc(opcode_reg)) begin
          ep_stat_reg[e][STALL_BIT] <= bus_wdata[0];
        end
      end else if (clk_en && ep_ack[e]) begin
        ep_stat_reg[e][FULL_BIT] <= 1'b1;
      end
    end

    // events set before selection clears, so none is lost
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        int_reg[e] <= 1'b0;
      end else if (clk_en) begin
        if (ep_ack[e] || (ep_nak[e] && mode_reg[NAK_BIT])) begin
          int_reg[e] <= 1'b1;
        end else if (wr_op && (is_sel(bus_wdata) || is_selc(bus_wdata))
                     && bus_wdata[2:0] == 3'(e)) begin
          int_reg[e] <= 1'b0;
        end
      end
    end
  end

  // reserved endpoint positions never set
  assign int_reg[NUM_EP_INT-1:NUM_EP] = '0;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      int_reg[DEV_INT_BIT]  <= 1'b0;
      int_reg[PORT_INT_BIT] <= 1'b0;
    end else if (clk_en) begin
      if (dev_stat_chg) begin
        int_reg[DEV_INT_BIT] <= 1'b1;
      end else if (port_rd) begin
        int_reg[DEV_INT_BIT] <= 1'b0;
      end
      if (usb_bus_reset) begin
        int_reg[PORT_INT_BIT] <= 1'b1;
      end else if (port_rd) begin
        int_reg[PORT_INT_BIT] <= 1'b0;
      end
    end
  end

  // error code and frame capture
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      error_reg <= {1'b0, ERR_NONE};
      frame_reg <= 11'h000;
    end else if (clk_en) begin
      if (err_pulse) begin
        error_reg <= {1'b1, err_code};
      end else if (xfer_start) begin
        error_reg[ERR_FLAG_BIT] <= 1'b0;
      end
      if (sof_pulse) begin
        frame_reg <= sof_frame;
      end
    end
  end

  // clock output divider, counting 48 mhz pin edges sampled on mclk
  logic       c48_q1, c48_q2, c48_q3;
  logic [7:0] div_cnt_reg;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      c48_q1 <= 1'b0;
      c48_q2 <= 1'b0;
      c48_q3 <= 1'b0;
    end else if (clk_en) begin
      c48_q1 <= clk48;
      c48_q2 <= c48_q1;
      c48_q3 <= c48_q2;
    end
  end

  // new factor taken only at period end, so no runt pulse
  logic       c48_rise;
  logic [7:0] div_act_reg;
  assign c48_rise = c48_q2 && !c48_q3;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_reg       <= 8'h00;
      div_act_reg       <= DIV_RESET;
      divided_clock_out <= 1'b0;
    end else if (clk_en && c48_rise) begin
      if (div_cnt_reg >= div_act_reg) begin
        div_cnt_reg       <= 8'h00;
        div_act_reg       <= div_reg;
        divided_clock_out <= 1'b1;
      end else begin
        div_cnt_reg <= div_cnt_reg + 8'h01;
        if (div_cnt_reg == (div_act_reg >> 1)) begin
          divided_clock_out <= 1'b0;
        end
      end
    end
  end

  // registered outputs
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      usb_int             <= 1'b0;
      pullup_select       <= 1'b0;
      keep_clocks_running <= 1'b0;
      report_refusals     <= 1'b0;
      dev_address         <= 7'h00;
      dev_enable          <= 1'b0;
      ep_enable           <= '0;
      port_connect        <= 1'b0;
    end else if (clk_en) begin
      usb_int             <= |int_reg;
      pullup_select       <= setup_reg[PULLUP_BIT];
      keep_clocks_running <= mode_reg[KEEPCLK_BIT];
      report_refusals     <= mode_reg[NAK_BIT];
      dev_address         <= addr_reg[6:0];
      dev_enable          <= addr_reg[7];
      ep_enable           <= ep_en_reg[NUM_EP-1:0];
      port_connect        <= port_conn_reg;
    end
  end
endmodule

// File: design/udcp_pkg.sv
// constants for the usb device command port: map, opcodes, fields
// assumes a byte-wide peripheral bus with one-cycle strobes
package udcp_pkg;
  localparam logic [15:0] ADDR_SETUP   = 16'h6000;
  localparam logic [15:0] ADDR_RDATA   = 16'h6001;
  localparam logic [15:0] ADDR_WDATA   = 16'h6002;
  localparam logic [15:0] ADDR_OPCODE  = 16'h6003;

  localparam logic [7:0] OP_CHIP_ID    = 8'hfd;
  localparam logic [7:0] OP_ERROR      = 8'hff;
  localparam logic [7:0] OP_FRAME      = 8'hf5;
  localparam logic [7:0] OP_INT_REG    = 8'hf4;
  localparam logic [7:0] OP_SET_MODE   = 8'hf3;
  localparam logic [7:0] OP_EP_ENABLE  = 8'hd8;
  localparam logic [7:0] OP_ADDRESS    = 8'hd0;
  localparam logic [7:0] OP_PORT_STAT  = 8'he0;
  localparam logic [7:0] OP_SEL_BASE   = 8'h00;
  localparam logic [7:0] OP_SEL_LAST   = 8'h06;
  localparam logic [7:0] OP_SELC_BASE  = 8'h40;
  localparam logic [7:0] OP_SELC_LAST  = 8'h46;
  localparam logic [7:0] OP_BUFFER     = 8'hf0;
  localparam logic [7:0] OP_CLR_BUF    = 8'hf2;
  localparam logic [7:0] OP_VALIDATE   = 8'hfa;

  localparam int          NUM_EP        = 7;
  localparam int          NUM_EP_INT    = 10;
  localparam int          BUF_DEPTH     = 64;
  localparam logic [7:0]  DIV_RESET     = 8'h03;
  localparam int          PULLUP_BIT    = 5;
  localparam int          NAK_BIT       = 0;
  localparam int          KEEPCLK_BIT   = 1;
  localparam int          ERR_FLAG_BIT  = 4;
  localparam int          DEV_INT_BIT   = 10;
  localparam int          PORT_INT_BIT  = 11;
  localparam int          FULL_BIT      = 0;
  localparam int          STALL_BIT     = 1;

  localparam logic [3:0] ERR_NONE      = 4'h0;
  localparam logic [3:0] ERR_PID_ENC   = 4'h1;
  localparam logic [3:0] ERR_PID_UNK   = 4'h2;
  localparam logic [3:0] ERR_UNEXP     = 4'h3;
  localparam logic [3:0] ERR_TOKEN_CRC = 4'h4;
  localparam logic [3:0] ERR_DATA_CRC  = 4'h5;
  localparam logic [3:0] ERR_TIMEOUT   = 4'h6;
  localparam logic [3:0] ERR_BABBLE    = 4'h7;
  localparam logic [3:0] ERR_EOP       = 4'h8;
  localparam logic [3:0] ERR_NAK_SENT  = 4'h9;
  localparam logic [3:0] ERR_STALL     = 4'ha;
  localparam logic [3:0] ERR_OVERRUN   = 4'hb;
  localparam logic [3:0] ERR_EMPTY_ISO = 4'hc;
  localparam logic [3:0] ERR_BITSTUFF  = 4'hd;
  localparam logic [3:0] ERR_SYNC      = 4'he;
  localparam logic [3:0] ERR_TOGGLE    = 4'hf;

  typedef enum logic [1:0] {
    UDCP_PH_IDLE,
    UDCP_PH_FIRST,
    UDCP_PH_SECOND,
    UDCP_PH_DONE
  } udcp_phase_e;
endpackage

// File: bench/udcp_checker.sv
// port checker for udcp_core, bound below the module
// assumes one mclk domain and reads issued only while rvalid is low
`timescale 1ns/100ps
module udcp_checker
  import udcp_pkg::*;
#(
  parameter logic [7:0] REVISION  = 8'h01,
  parameter logic [3:0] PART_NAME = 4'h5
) (
  input wire logic         mclk,       // clock
  input wire logic         rst_n,      // reset
  input wire logic         clk_en,     // run
  input wire logic [15:0]  bus_addr,   // address
  input wire logic         bus_wr,     // write
  input wire logic         bus_rd,     // read
  input wire logic [7:0]   bus_wdata,  // wdata
  input wire logic [7:0]   bus_rdata,  // rdata
  input wire logic         bus_rvalid, // rvalid
  input wire logic         bus_rready, // rready
  input wire logic [NUM_EP-1:0] ep_ack, // acks
  input wire logic         usb_int,    // irq
  input wire logic         pullup_select,       // pull-up
  input wire logic         keep_clocks_running, // clocks
  input wire logic         report_refusals,     // nak
  input wire logic [6:0]   dev_address, // address
  input wire logic         dev_enable,  // enable
  input wire logic [NUM_EP-1:0] ep_enable, // ep on
  input wire logic         port_connect // port
);
  logic [7:0] op_reg;
  logic [2:0] wn_reg, rn_reg;
  wire opw = clk_en && bus_wr && bus_addr == ADDR_OPCODE;
  wire dw  = clk_en && bus_wr && bus_addr == ADDR_WDATA;
  // only reads into an empty buffer count, so refused ones never skew
  wire rq  = clk_en && bus_rd && bus_addr == ADDR_RDATA && !bus_rvalid;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      op_reg <= 8'h00;
      wn_reg <= 3'h0;
      rn_reg <= 3'h0;
    end else if (opw) begin
      op_reg <= bus_wdata;
      wn_reg <= 3'h0;
      rn_reg <= 3'h0;
    end else begin
      if (dw && wn_reg != 3'h7) wn_reg <= wn_reg + 3'h1;
      if (rq && rn_reg != 3'h7) rn_reg <= rn_reg + 3'h1;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_rvalid_holds: assert property (
    bus_rvalid && !bus_rready |=> bus_rvalid && $stable(bus_rdata))
    else $error("read data dropped");
  a_id_low: assert property (
    op_reg == OP_CHIP_ID && rn_reg == 3'h0 && rq
    |=> bus_rvalid && bus_rdata == REVISION) else $error("id byte0");
  a_id_high: assert property (
    op_reg == OP_CHIP_ID && rn_reg == 3'h1 && rq
    |=> bus_rvalid && bus_rdata == {4'h0, PART_NAME})
    else $error("id byte1");
  a_setup_pull: assert property (
    clk_en && bus_wr && bus_addr == ADDR_SETUP
    |=> ##1 pullup_select == $past(bus_wdata[5], 2)) else $error("pull-up");
  a_mode_bits: assert property (
    op_reg == OP_SET_MODE && wn_reg == 3'h0 && dw
    |=> ##1
    {keep_clocks_running, report_refusals} == $past(bus_wdata[1:0], 2))
    else $error("mode bits");
  a_addr_set: assert property (
    op_reg == OP_ADDRESS && wn_reg == 3'h0 && dw
    |=> ##1 {dev_enable, dev_address} == $past(bus_wdata, 2))
    else $error("address");
  a_ep_set: assert property (
    op_reg == OP_EP_ENABLE && wn_reg == 3'h0 && dw
    |=> ##1 ep_enable == $past(bus_wdata[6:0], 2)) else $error("ep enable");
  a_port_set: assert property (
    op_reg == OP_PORT_STAT && wn_reg == 3'h0 && dw
    |=> ##1 port_connect == $past(bus_wdata[0], 2)) else $error("port");
  a_int_ack: assert property (
    clk_en && ep_ack != '0 |-> ##[1:2] usb_int) else $error("irq");
endmodule
bind udcp_core udcp_checker #(
  .REVISION(REVISION),
  .PART_NAME(PART_NAME)
) u_chk (
  .mclk, .rst_n, .clk_en, .bus_addr, .bus_wr, .bus_rd, .bus_wdata,
  .bus_rdata, .bus_rvalid, .bus_rready, .ep_ack, .usb_int,
  .pullup_select, .keep_clocks_running, .report_refusals,
  .dev_address, .dev_enable, .ep_enable, .port_connect
);

// File: bench/udcp_cpu_model.sv
// microcontroller side of the command port: byte writes and reads
// assumes strobes launched on the falling edge of mclk
`timescale 1ns/100ps
module udcp_cpu_model
  import udcp_pkg::*;
(
  input  wire logic        mclk,       // bus clock
  input  wire logic        bus_rvalid, // read valid
  input  wire logic [7:0]  bus_rdata,  // read data
  output logic      [15:0] bus_addr,   // address
  output logic             bus_wr,     // write strobe
  output logic             bus_rd,     // read request
  output logic      [7:0]  bus_wdata,  // write data
  output logic             bus_rready  // takes read data
);
  initial {bus_addr, bus_wr, bus_rd, bus_wdata, bus_rready} = '0;
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge mclk);
    bus_addr  = a;
    bus_wdata = d;
    bus_wr    = 1'b1;
    @(negedge mclk);
    bus_wr    = 1'b0;
    bus_addr  = 16'h0000; // parked off the map
    bus_wdata = ~d;       // stale data must not look valid
    @(negedge mclk);
  endtask
  task automatic op(input logic [7:0] c);
    wr(ADDR_OPCODE, c);
  endtask
  task automatic wd(input logic [7:0] d);
    wr(ADDR_WDATA, d);
  endtask
  task automatic rq();
    @(negedge mclk);
    bus_addr = ADDR_RDATA;
    bus_rd   = 1'b1;
    @(negedge mclk);
    bus_rd   = 1'b0;
    bus_addr = 16'h0000;
  endtask
  task automatic take(output logic [7:0] d);
    @(negedge mclk);
    bus_rready = 1'b1;
    for (int n = 0; n < 16 && !bus_rvalid; n++) @(negedge mclk);
    d = bus_rvalid ? bus_rdata : 8'hxx; // a missing answer never matches
    @(negedge mclk);
    bus_rready = 1'b0;
  endtask
  task automatic rd(output logic [7:0] d);
    rq();
    take(d);
  endtask
endmodule

// File: bench/tb.sv
// bench for udcp_core through the cpu model's byte tasks
// assumes clk48 slowed to 5 mhz so mclk can sample it
`timescale 1ns/100ps
module tb
  import udcp_pkg::*;
;
  localparam logic [7:0] REV = 8'h3c; // arbitrary value
  localparam logic [3:0] PN  = 4'ha;  // arbitrary value
  logic mclk, rst_n, clk_en, clk48, ubr, sof, errp, xfer, devc;
  logic [10:0] frame;
  logic [3:0] ecode;
  logic [NUM_EP-1:0] ack, nak;
  logic [15:0] bus_addr;
  logic bus_wr, bus_rd, bus_rvalid, bus_rready, usb_int, divided_clock_out;
  logic pullup_select, keep_clocks_running, report_refusals;
  logic dev_enable, port_connect;
  logic [7:0] bus_wdata, bus_rdata, d;
  logic [6:0] dev_address;
  logic [NUM_EP-1:0] ep_enable;
  int failures = 0, n_compared = 0;
  realtime p;
  initial begin
    {rst_n, clk48, ubr, sof, errp, xfer, devc} = '0;
    {frame, ecode, ack, nak} = '0;
    clk_en = 1'b1;
  end
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial forever #100 clk48 = ~clk48;
  udcp_core #(.REVISION(REV), .PART_NAME(PN)) i_dut (
    .mclk, .rst_n, .clk_en, .clk48, .bus_addr, .bus_wr, .bus_rd,
    .bus_wdata, .bus_rdata, .bus_rvalid, .bus_rready,
    .usb_bus_reset(ubr), .sof_pulse(sof), .sof_frame(frame),
    .err_pulse(errp), .err_code(ecode), .xfer_start(xfer),
    .ep_ack(ack), .ep_nak(nak), .dev_stat_chg(devc), .usb_int,
    .divided_clock_out, .pullup_select, .keep_clocks_running,
    .report_refusals, .dev_address, .dev_enable, .ep_enable,
    .port_connect);
  udcp_cpu_model u_cpu (.mclk, .bus_rvalid, .bus_rdata, .bus_addr,
    .bus_wr, .bus_rd, .bus_wdata, .bus_rready);
  task automatic test_done();
    if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_t(input string nm, input int e, input realtime g);
    n_compared++;
    if (g < e - 41 || g > e + 41) begin
      failures++;
      $display("wrong value %s expected %0d seen %0d", nm, e, int'(g));
    end
  endtask
  task automatic rchk(input string nm, input logic [7:0] e);
    u_cpu.rd(d);
    chk(nm, e, d);
  endtask
  // one-cycle engine events; qualifiers are scrambled once used
  task automatic ev(input logic [4:0] m, input logic [NUM_EP-1:0] a,
                    input logic [NUM_EP-1:0] n);
    @(negedge mclk);
    {ubr, devc, sof, xfer, errp} = m;
    ack = a;
    nak = n;
    @(negedge mclk);
    {ubr, devc, sof, xfer, errp} = 5'h00;
    ack = '0;
    nak = '0;
    ecode = ~ecode;
    frame = ~frame;
  endtask
  task automatic meas(output realtime q);
    realtime t0;
    @(posedge divided_clock_out);
    t0 = $realtime;
    @(posedge divided_clock_out);
    q = $realtime - t0;
  endtask
  initial begin
    #400000;
    failures++;
    test_done();
  end
  initial begin
    repeat (4) @(negedge mclk);
    rst_n = 1;
    chk("pull-up reset", 8'h00, {7'h0, pullup_select});
    u_cpu.op(OP_CHIP_ID);
    rchk("id low", REV);
    rchk("id high", {4'h0, PN});
    for (int i = 0; i < 16; i++) begin
      ecode = 4'(i);
      ev(5'h01, '0, '0);
      u_cpu.op(OP_ERROR);
      rchk("error", {4'h1, 4'(i)});
      ev(5'h02, '0, '0);
      u_cpu.op(OP_ERROR);
      rchk("error flag", {4'h0, 4'(i)});
    end
    frame = 11'h5a3;
    ev(5'h04, '0, '0);
    u_cpu.op(OP_FRAME);
    rchk("frame low", 8'ha3);
    rchk("frame high", 8'h05);
    for (int k = 0; k < NUM_EP; k++) begin
      ev(5'h00, 7'(1 << k), '0);
      u_cpu.op(OP_INT_REG);
      rchk("int low", 8'(1 << k));
      rchk("int high", 8'h00);
      u_cpu.op(k[0] ? OP_SELC_BASE + 8'(k) : 8'(k));
      if (k[0]) rchk("select clear", 8'h01);
      u_cpu.op(OP_INT_REG);
      rchk("int cleared", 8'h00);
      rchk("int cleared", 8'h00);
    end
    ev(5'h08, '0, '0);
    u_cpu.op(OP_INT_REG);
    rchk("dev low", 8'h00);
    rchk("dev high", 8'h04);
    u_cpu.op(OP_PORT_STAT);
    u_cpu.rd(d);
    u_cpu.op(OP_INT_REG);
    rchk("dev low", 8'h00);
    rchk("dev clear", 8'h00);
    ev(5'h00, '0, 7'h02);
    u_cpu.op(OP_INT_REG);
    rchk("nak off", 8'h00);
    u_cpu.op(OP_SET_MODE);
    u_cpu.wd(8'h01);
    u_cpu.wd(DIV_RESET);
    chk("refusals", 8'h01, {7'h0, report_refusals});
    ev(5'h00, '0, 7'h02);
    u_cpu.op(OP_INT_REG);
    rchk("nak on", 8'h02);
    u_cpu.op(8'h01);
    u_cpu.wr(ADDR_SETUP, 8'h20);
    chk("pull-up ext", 8'h01, {7'h0, pullup_select});
    u_cpu.wr(ADDR_SETUP, 8'hdf);
    chk("pull-up int", 8'h00, {7'h0, pullup_select});
    meas(p);
    chk_t("period div3", 800, p);
    u_cpu.op(OP_SET_MODE);
    u_cpu.wd(8'h02);
    u_cpu.wd(8'h01);
    chk("keep clocks", 8'h01, {7'h0, keep_clocks_running});
    meas(p);
    meas(p);
    chk_t("period div1", 400, p);
    ev(5'h10, '0, '0);
    meas(p);
    chk_t("period bus reset", 400, p);
    u_cpu.op(OP_SET_MODE);
    u_cpu.wd(8'h00);
    u_cpu.wd(8'h01);
    u_cpu.op(OP_ADDRESS);
    u_cpu.wd(8'h85);
    chk("address", 8'h85, {dev_enable, dev_address});
    clk_en = 1'b0;
    u_cpu.op(OP_ADDRESS);
    u_cpu.wd(8'h12);
    clk_en = 1'b1;
    chk("frozen", 8'h85, {dev_enable, dev_address});
    u_cpu.op(OP_EP_ENABLE);
    u_cpu.wd(8'h55);
    u_cpu.wd(8'h00);
    chk("ep enable", 8'h55, {1'b0, ep_enable});
    u_cpu.op(OP_PORT_STAT);
    u_cpu.wd(8'h01);
    chk("connect", 8'h01, {7'h0, port_connect});
    u_cpu.op(OP_SEL_LAST);
    u_cpu.op(OP_VALIDATE);
    u_cpu.op(OP_SEL_LAST);
    rchk("full", 8'h01);
    u_cpu.op(OP_SELC_LAST);
    u_cpu.wd(8'h01);
    u_cpu.op(OP_SEL_LAST);
    rchk("stall", 8'h03);
    u_cpu.op(OP_CLR_BUF);
    u_cpu.op(OP_SEL_LAST);
    rchk("cleared", 8'h02);
    u_cpu.op(OP_BUFFER);
    u_cpu.wd(8'ha1);
    u_cpu.wd(8'hb2);
    u_cpu.op(OP_SEL_LAST);
    u_cpu.op(OP_BUFFER);
    rchk("buffer", 8'ha1);
    rchk("buffer", 8'hb2);
    frame = 11'h2c4;
    ev(5'h04, '0, '0);
    u_cpu.op(OP_FRAME);
    u_cpu.rq();
    u_cpu.rq();
    u_cpu.rq(); // buffer full, dropped
    u_cpu.take(d);
    chk("stalled low", 8'hc4, d);
    u_cpu.take(d);
    chk("stalled high", 8'h02, d);
    repeat (3) @(negedge mclk);
    chk("drained", 8'h00, {7'h0, bus_rvalid});
    test_done();
  end
endmodule
